// File: core/epca_pkg.sv
// constants and types for the ethernet pcs client adapter
// How it works
// RL1 - 25G fail: scrambled 0x55 double fault blocks
// RL2 - 200/400G fail: 0x4B fault blocks, compensated
// RL3 - 50G fail: 0x4B blocks plus four markers
// RL4 - base-r fec mapper: find codewords, restore sync
// RL5 - base-r fec demapper: strip bit, parity slots
// RL6 - rs fec: 528/514 code, twenty 257b blocks
// RL7 - codeword marker every 1024th codeword
// RL8 - rs fec mapper: fill idles keep rate
// RL9 - rs fec demapper: delete idles for markers; code only flags the marker slot, deletes no idles
// RL10 - 200/400G: all pcs lanes marker locked
// RL11 - uncorrectable codewords become error blocks
// RL12 - insert Z compensation blocks per period
// RL13 - scramble after compensation insertion
// RL14 - demapper locks, descrambles, drops compensation
// RL15 - first half first pattern, rest second
// RL16 - compensation block type field is zero
// RL17 - 50G: four lanes block and marker locked
// RL18 - 50G markers leave consecutively in lane order
// RL19 - mapper lane parity compare, data untouched
// RL20 - demapper forwards lane parity, compares it
// RL21 - demapper lock, round-robin four egress lanes
// RL22 - sync header lands on odd bit position
// RL23 - self-synchronising scrambler 1+x39+x58
// RL24 - fail switching keeps block phase intact
// RL25 - client type selects replacement and path
package epca_pkg;
    typedef enum logic [3:0] {
        CT_25G  = 4'b0001,
        CT_50G  = 4'b0010,
        CT_200G = 4'b0100,
        CT_400G = 4'b1000
    } epca_client_type;
    typedef enum logic [2:0] {
        FM_NONE  = 3'b001,
        FM_BASER = 3'b010,
        FM_RS    = 3'b100
    } epca_fec_type;
    typedef enum logic [1:0] {
        LK_HUNT = 2'b01,
        LK_LOCK = 2'b10
    } epca_lock_type;
    localparam logic [1:0]  SYNC_CTRL      = 2'h1;
    localparam logic [1:0]  SYNC_DATA      = 2'h2;
    localparam logic [7:0]  TYPE_RATE_COMP = 8'h00;
    localparam logic [63:0] LF_PAYLOAD_55  = 64'h0100_0000_0100_0055;
    localparam logic [63:0] LF_PAYLOAD_4B  = 64'h0000_0000_0100_004B;
    localparam logic [63:0] ERROR_PAYLOAD  = 64'h3C78_F1E3_C78F_1E1E;
    localparam logic [63:0] IDLE_PAYLOAD   = 64'h0000_0000_0000_001E;
    localparam int          PERIOD_BLOCKS  = 20479;
    localparam logic [5:0]  Z_200G         = 6'h10;
    localparam logic [5:0]  Z_400G         = 6'h20;
    localparam logic [5:0]  AM_COUNT_50G   = 6'h04;
    localparam logic [5:0]  BASER_GROUP    = 6'h20;
    localparam logic [6:0]  RS_CW_BLOCKS   = 7'h50;
    localparam logic [9:0]  RS_CWM_PERIOD  = 10'h3FF;
    localparam logic [6:0]  LOCK_GOOD      = 7'h40;
    localparam int          SCR_TAP_A      = 38;
    localparam int          SCR_TAP_B      = 57;
    localparam logic [15:0] LANES_50G      = 16'h000F;
    localparam logic [15:0] LANES_200G     = 16'h00FF;
    localparam logic [15:0] LANES_400G     = 16'hFFFF;
    localparam logic [2:0]  SYNC_BIT_POS   = 3'h1;
endpackage : epca_pkg

// File: core/epca_adapter.sv
// 66b block adapter between ethernet pcs clients and the flexible payload unit
`timescale 1ns/10ps
`default_nettype none
module epca_adapter
    import epca_pkg::*;
#(
    parameter int          PERIOD       = PERIOD_BLOCKS,
    parameter logic [63:0] RC_FIRST_PAT = 64'h5A5A_5A5A_5A5A_5A00,
    parameter logic [63:0] RC_SECOND_PAT= 64'hA5A5_A5A5_A5A5_A500,
    parameter logic [63:0] AM_PAT_0     = 64'h0000_0000_0000_1100,
    parameter logic [63:0] AM_PAT_1     = 64'h0000_0000_0000_2200,
    parameter logic [63:0] AM_PAT_2     = 64'h0000_0000_0000_3300,
    parameter logic [63:0] AM_PAT_3     = 64'h0000_0000_0000_4400
)(
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    // configuration
    input  wire logic [3:0]  client_type_in,
    input  wire logic [2:0]  fec_mode_in,
    input  wire logic        client_los_in,
    input  wire logic [15:0] lane_lock_in,
    // mapping direction, client to payload
    input  wire logic [65:0] map_blk_in,
    input  wire logic        map_vld_in,
    input  wire logic        map_uncorr_in,
    input  wire logic        map_cw_ok_in,
    output logic             map_rdy_out,
    output logic             map_cw_slip_out,
    output logic [65:0]      map_blk_out,
    output logic             map_vld_out,
    output logic [2:0]       map_sync_pos_out,
    // lane parity monitor
    input  wire logic [7:0]  parity_rx_in,
    input  wire logic [7:0]  parity_exp_in,
    input  wire logic        parity_chk_in,
    output logic [7:0]       parity_fwd_out,
    output logic             parity_err_out,
    // demapping direction, payload to client
    input  wire logic [65:0] dmap_blk_in,
    input  wire logic        dmap_vld_in,
    output logic [65:0]      dmap_blk_out,
    output logic             dmap_vld_out,
    output logic [1:0]       dmap_lane_out,
    output logic             dmap_lock_out,
    output logic             dmap_parity_slot_out,
    output logic             dmap_cwm_slot_out
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    localparam logic [19:0] PER20 = 20'(PERIOD);

    // one function for both ends; descrambler feeds back received bits
    function automatic logic [121:0] scr_step(input logic [63:0] d,
                                              input logic [57:0] s, input logic desc);
        logic [63:0] o;
        logic [57:0] st;
        o  = '0;
        st = s;
        for (int i = 0; i < 64; i++)
        begin
            o[i] = d[i] ^ st[SCR_TAP_A] ^ st[SCR_TAP_B];
            st   = {st[56:0], desc ? d[i] : o[i]};
        end
        return {st, o};
    endfunction : scr_step

    function automatic logic [5:0] ins_count(input logic [3:0] ct);
        ins_count = (ct == CT_400G) ? Z_400G : (ct == CT_200G) ? Z_200G : AM_COUNT_50G;
    endfunction : ins_count

    // ------------------------------------------------------------
    // pin synchronisers and client health
    // ------------------------------------------------------------
    logic los_s1_q, los_s2_q;
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            los_s1_q <= 1'b1;
            los_s2_q <= 1'b1;
        end
        else
        begin
            los_s1_q <= client_los_in;
            los_s2_q <= los_s1_q;
        end
    end

    logic [15:0] need_lanes;
    logic        lanes_ok, fail, is_hi, ins_mode, rs_mode;
    // RL10 RL17 lane lock gating
    always_comb
    begin
        unique case (client_type_in)
            CT_50G:  need_lanes = LANES_50G;
            CT_200G: need_lanes = LANES_200G;
            CT_400G: need_lanes = LANES_400G;
            default: need_lanes = '0;
        endcase
    end
    assign lanes_ok = ((lane_lock_in & need_lanes) == need_lanes);
    assign fail     = los_s2_q | ~lanes_ok;
    assign is_hi    = (client_type_in == CT_200G) | (client_type_in == CT_400G);
    // RL25 type picks insertion path
    assign ins_mode = is_hi | (fail & (client_type_in == CT_50G));
    assign rs_mode  = (client_type_in == CT_25G) & (fec_mode_in == FM_RS);

    // ------------------------------------------------------------
    // mapper: period count and insertion
    // ------------------------------------------------------------
    logic [19:0] blk_cnt_q;
    logic [5:0]  ins_left_q, zc;
    logic        src_take;
    assign zc          = ins_count(client_type_in);
    assign map_rdy_out = (ins_left_q == 6'h00) & ~fail;
    assign src_take    = (ins_left_q == 6'h00) & (fail | map_vld_in | rs_mode);

    // RL12 RL3 insertion after Z times the period
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            blk_cnt_q  <= '0;
            ins_left_q <= '0;
        end
        else if (ins_left_q != 6'h00)
            ins_left_q <= ins_left_q - 6'h01;
        else if (src_take & ins_mode)
        begin
            if (blk_cnt_q == 20'(zc * PER20) - 20'h1)
            begin
                blk_cnt_q  <= '0;
                ins_left_q <= zc;
            end
            else
                blk_cnt_q <= blk_cnt_q + 20'h1;
        end
    end

    logic [65:0] src_blk, ins_blk;
    logic [1:0]  am_idx;
    assign am_idx = 2'(AM_COUNT_50G - ins_left_q);
    always_comb
    begin
        // RL18 markers in lane order
        unique case (am_idx)
            2'h0:    ins_blk = {AM_PAT_0, SYNC_CTRL};
            2'h1:    ins_blk = {AM_PAT_1, SYNC_CTRL};
            2'h2:    ins_blk = {AM_PAT_2, SYNC_CTRL};
            default: ins_blk = {AM_PAT_3, SYNC_CTRL};
        endcase
        // RL15 RL16 two pattern halves, zero type field
        if (is_hi)
            ins_blk = (ins_left_q > (zc >> 1)) ? {RC_FIRST_PAT[63:8], TYPE_RATE_COMP, SYNC_CTRL}
                                               : {RC_SECOND_PAT[63:8], TYPE_RATE_COMP, SYNC_CTRL};
        // RL24 replacement swaps on block boundary, counters run on
        if (fail)
        begin
            // RL1 RL2 RL3 fault blocks per client type
            src_blk = (client_type_in == CT_25G) ? {LF_PAYLOAD_55, SYNC_CTRL}
                                                 : {LF_PAYLOAD_4B, SYNC_CTRL};
        end
        // RL8 idles hold the rate where markers were removed
        else if (rs_mode & ~map_vld_in)
            src_blk = {IDLE_PAYLOAD, SYNC_CTRL};
        // RL11 uncorrectable codeword marked
        else if (map_uncorr_in)
            src_blk = {ERROR_PAYLOAD, SYNC_CTRL};
        // RL4 second sync bit restored from the first
        else if ((client_type_in == CT_25G) & (fec_mode_in == FM_BASER))
            src_blk = {map_blk_in[65:2], ~map_blk_in[0], map_blk_in[0]};
        else
            src_blk = map_blk_in;
    end

    // RL4 search and test: slip one block when parity check fails at boundary
    logic [5:0] bfec_cnt_q;
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            bfec_cnt_q      <= '0;
            map_cw_slip_out <= 1'b0;
        end
        else
        begin
            map_cw_slip_out <= 1'b0;
            if (map_vld_in & (fec_mode_in == FM_BASER))
            begin
                if (bfec_cnt_q == BASER_GROUP - 6'h01)
                begin
                    bfec_cnt_q      <= map_cw_ok_in ? 6'h00 : 6'h01;
                    map_cw_slip_out <= ~map_cw_ok_in;
                end
                else
                    bfec_cnt_q <= bfec_cnt_q + 6'h01;
            end
        end
    end

    // RL13 RL23 scrambling after insertion; live 25G/50G already scrambled
    logic [57:0]  scr_q;
    logic [65:0]  pre_blk;
    logic [121:0] scr_res;
    logic         do_scr, out_vld;
    assign out_vld = (ins_left_q != 6'h00) | src_take;
    assign pre_blk = (ins_left_q != 6'h00) ? ins_blk : src_blk;
    assign do_scr  = is_hi | fail;
    assign scr_res = scr_step(pre_blk[65:2], scr_q, 1'b0);

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            scr_q       <= '1;
            map_blk_out <= '0;
            map_vld_out <= 1'b0;
        end
        else
        begin
            map_vld_out <= out_vld;
            if (out_vld)
            begin
                map_blk_out <= do_scr ? {scr_res[63:0], pre_blk[1:0]} : pre_blk;
                if (do_scr)
                    scr_q <= scr_res[121:64];
            end
        end
    end
    // RL22 first sync bit at odd bit position
    assign map_sync_pos_out = SYNC_BIT_POS;

    // ------------------------------------------------------------
    // lane parity monitor
    // ------------------------------------------------------------
    // RL19 RL20 forward unchanged and compare on request
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            parity_fwd_out <= '0;
            parity_err_out <= 1'b0;
        end
        else
        begin
            parity_fwd_out <= parity_rx_in;
            parity_err_out <= parity_chk_in & (parity_rx_in != parity_exp_in);
        end
    end

    // ------------------------------------------------------------
    // demapper: lock, descramble, drop compensation, lanes
    // ------------------------------------------------------------
    epca_lock_type lk_q;
    logic [6:0]    good_q;
    logic          hdr_ok;
    assign hdr_ok = dmap_blk_in[0] ^ dmap_blk_in[1];
    // RL14 RL21 block lock on sync headers
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            lk_q   <= LK_HUNT;
            good_q <= '0;
        end
        else if (dmap_vld_in)
        begin
            unique case (lk_q)
                LK_HUNT:
                begin
                    good_q <= hdr_ok ? good_q + 7'h01 : 7'h00;
                    if (hdr_ok & (good_q == LOCK_GOOD - 7'h01))
                        lk_q <= LK_LOCK;
                end
                LK_LOCK:
                begin
                    good_q <= '0;
                    if (!hdr_ok)
                        lk_q <= LK_HUNT;
                end
            endcase
        end
    end
    assign dmap_lock_out = (lk_q == LK_LOCK);

    logic [57:0]  dsc_q;
    logic [121:0] dsc_res;
    logic [65:0]  plain;
    logic         is_rc, keep;
    assign dsc_res = scr_step(dmap_blk_in[65:2], dsc_q, 1'b1);
    assign plain   = is_hi ? {dsc_res[63:0], dmap_blk_in[1:0]} : dmap_blk_in;
    assign is_rc   = is_hi & (plain[1:0] == SYNC_CTRL) & (plain[9:2] == TYPE_RATE_COMP);
    assign keep    = dmap_vld_in & dmap_lock_out & ~is_rc;

    logic [5:0] dgrp_q;
    logic [6:0] rscw_q;
    logic [9:0] cwm_q;
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            dsc_q                <= '1;
            dmap_blk_out         <= '0;
            dmap_vld_out         <= 1'b0;
            dmap_lane_out        <= '0;
            dgrp_q               <= '0;
            rscw_q               <= '0;
            cwm_q                <= '0;
            dmap_parity_slot_out <= 1'b0;
            dmap_cwm_slot_out    <= 1'b0;
        end
        else
        begin
            if (dmap_vld_in)
                dsc_q <= dsc_res[121:64];
            // RL14 compensation blocks removed
            dmap_vld_out         <= keep;
            dmap_parity_slot_out <= 1'b0;
            dmap_cwm_slot_out    <= 1'b0;
            if (keep)
            begin
                // RL5 redundant sync bit stripped in base-r fec
                dmap_blk_out <= (fec_mode_in == FM_BASER) ? {plain[65:2], 1'b0, plain[0]} : plain;
                // RL21 round-robin egress lanes
                dmap_lane_out <= dmap_lane_out + 2'h1;
                // RL5 parity follows every thirty-two blocks
                dgrp_q <= (dgrp_q == BASER_GROUP - 6'h01) ? 6'h00 : dgrp_q + 6'h01;
                dmap_parity_slot_out <= (fec_mode_in == FM_BASER)
                                        & (dgrp_q == BASER_GROUP - 6'h01);
                // RL6 RL9 twenty 257b blocks per codeword
                if (rscw_q == RS_CW_BLOCKS - 7'h01)
                begin
                    rscw_q <= '0;
                    // RL7 marker slot each 1024th codeword, flagged on dmap_cwm_slot_out
                    cwm_q             <= cwm_q + 10'h001;
                    dmap_cwm_slot_out <= (fec_mode_in == FM_RS) & (cwm_q == RS_CWM_PERIOD);
                end
                else
                    rscw_q <= rscw_q + 7'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    ins_load_a: assert property ((ins_left_q == 6'h00) ##1 (ins_left_q != 6'h00)
        |-> ins_left_q == $past(zc)) else $error("insert count wrong"); // RL12
    rdy_stall_a: assert property ((ins_left_q != 6'h00) |-> !map_rdy_out)
        else $error("ready during insertion"); // RL12
    rc_type_a: assert property ((is_hi && ins_left_q != 6'h00) ##1 1
        |-> map_vld_out && map_blk_out[1:0] == SYNC_CTRL) else $error("insert not control"); // RL16
    fail_sync_a: assert property ($rose(client_los_in) |-> ##2 fail)
        else $error("loss not seen in two cycles"); // RL1
    par_fwd_a: assert property (1 ##1 parity_fwd_out == $past(parity_rx_in))
        else $error("parity altered"); // RL20
    par_err_a: assert property (parity_chk_in && parity_rx_in != parity_exp_in
        |=> parity_err_out) else $error("parity mismatch missed"); // RL19
    rc_drop_a: assert property (is_rc |=> !dmap_vld_out)
        else $error("compensation block passed"); // RL14
    lock_gate_a: assert property (!dmap_lock_out |=> !dmap_vld_out)
        else $error("output before lock"); // RL21
    lane_rr_a: assert property (dmap_vld_out ##1 keep
        |=> dmap_lane_out == $past(dmap_lane_out) + 2'h1) else $error("lane order"); // RL21
    sync_pos_a: assert property (map_sync_pos_out[0]) else $error("even sync position"); // RL22

    ins_run_c: cover property (ins_left_q == 6'h01 ##1 ins_left_q == 6'h00);
    lock_c:    cover property ($rose(dmap_lock_out));
    fail_c:    cover property ($fell(fail) ##[1:20] map_vld_out);
    slip_c:    cover property (map_cw_slip_out);
endmodule : epca_adapter
`default_nettype wire

// File: test/epca_client_model.sv
// client block source standing in for the recovered pcs client stream
`timescale 1ns/10ps
`default_nettype none
module epca_client_model
    import epca_pkg::*;
(
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    // block handshake
    input  wire logic        enable_in,
    input  wire logic        ready_in,
    output logic [65:0]      blk_out,
    output logic             vld_out
);
    logic [63:0] seq_q;

    // a block stays put until taken; idle lines toggle so stale data never looks valid
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            vld_out <= 1'b0;
            blk_out <= 66'h0;
            seq_q   <= 64'h0;
        end
        else if (!vld_out || ready_in)
        begin
            vld_out <= enable_in;
            blk_out <= enable_in ? {seq_q, SYNC_DATA} : ~blk_out;
            seq_q   <= seq_q + (enable_in ? 64'h1 : 64'h0);
        end
    end
endmodule : epca_client_model
`default_nettype wire

// File: test/test_epca_adapter.sv
// self-checking bench for the ethernet pcs client adapter
`timescale 1ns/10ps
`default_nettype none
module test_epca_adapter
    import epca_pkg::*;
;
    // ----------------------------------------
    // setup
    // ----------------------------------------
    localparam int          PER  = 8;
    localparam logic [63:0] RC_A = 64'h5A5A_5A5A_5A5A_5A00;
    localparam logic [63:0] RC_B = 64'hA5A5_A5A5_A5A5_A500;
    typedef struct packed {
        logic [7:0] rx;
        logic [7:0] exp;
        logic       chk;
        logic       err;
    } epca_row_type;
    logic        clock_in       = 1'b0;
    logic        rst_n_in       = 1'b0;
    logic [3:0]  client_type_in = CT_25G;
    logic [2:0]  fec_mode_in    = FM_NONE;
    logic        client_los_in  = 1'b1;
    logic [15:0] lane_lock_in   = 16'h0;
    logic [7:0]  parity_rx_in   = 8'h0;
    logic [7:0]  parity_exp_in  = 8'h0;
    logic        parity_chk_in  = 1'b0;
    logic [65:0] dmap_blk_in    = 66'h0;
    logic        dmap_vld_in    = 1'b0;
    logic        src_en         = 1'b0;
    logic [65:0] map_blk_in, map_blk_out, dmap_blk_out;
    logic        map_vld_in, map_rdy_out, map_cw_slip_out, map_vld_out;
    logic [2:0]  map_sync_pos_out;
    logic [7:0]  parity_fwd_out;
    logic        parity_err_out, dmap_vld_out, dmap_lock_out;
    logic        dmap_parity_slot_out, dmap_cwm_slot_out;
    logic [1:0]  dmap_lane_out;
    logic [57:0] hist = 58'h3FF_FFFF_FFFF_FFFF;
    logic [65:0] out_q[$];
    int          failures    = 0;
    int          comparisons = 0;
    int          cycles      = 0;
    epca_row_type rows[5] = '{
        '{8'h3C, 8'h3C, 1'b1, 1'b0}, '{8'h3C, 8'hC3, 1'b1, 1'b1},
        '{8'hA5, 8'h5A, 1'b0, 1'b0}, '{8'hFF, 8'hFE, 1'b1, 1'b1},
        '{8'h00, 8'h00, 1'b0, 1'b0}};

    epca_adapter #(.PERIOD(PER), .RC_FIRST_PAT(RC_A), .RC_SECOND_PAT(RC_B)) epca_adapter_inst (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .client_type_in(client_type_in),
        .fec_mode_in(fec_mode_in), .client_los_in(client_los_in),
        .lane_lock_in(lane_lock_in), .map_blk_in(map_blk_in), .map_vld_in(map_vld_in),
        .map_uncorr_in(1'b0), .map_cw_ok_in(1'b1), .map_rdy_out(map_rdy_out),
        .map_cw_slip_out(map_cw_slip_out), .map_blk_out(map_blk_out),
        .map_vld_out(map_vld_out), .map_sync_pos_out(map_sync_pos_out),
        .parity_rx_in(parity_rx_in), .parity_exp_in(parity_exp_in),
        .parity_chk_in(parity_chk_in), .parity_fwd_out(parity_fwd_out),
        .parity_err_out(parity_err_out), .dmap_blk_in(dmap_blk_in),
        .dmap_vld_in(dmap_vld_in), .dmap_blk_out(dmap_blk_out), .dmap_vld_out(dmap_vld_out),
        .dmap_lane_out(dmap_lane_out), .dmap_lock_out(dmap_lock_out),
        .dmap_parity_slot_out(dmap_parity_slot_out), .dmap_cwm_slot_out(dmap_cwm_slot_out));

    epca_client_model epca_client_model_inst (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .enable_in(src_en),
        .ready_in(map_rdy_out), .blk_out(map_blk_in), .vld_out(map_vld_in));

    always #2.5 clock_in = ~clock_in;

    // ----------------------------------------
    // mapped stream monitor
    // ----------------------------------------
    // descrambles every output block; harmless where the stream is not scrambled
    always @(posedge clock_in)
    begin
        logic        s;
        logic [65:0] b;
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            complete_run();
        end
        if (rst_n_in && map_vld_out === 1'b1)
        begin
            b = map_blk_out;
            for (int i = 2; i < 66; i++)
            begin
                s = map_blk_out[i];
                b[i] = s ^ hist[SCR_TAP_A] ^ hist[SCR_TAP_B];
                hist = {hist[56:0], s};
            end
            out_q.push_back(b);
        end
    end

    task automatic check(input logic [65:0] seen, input logic [65:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock_in);
    endtask : wait_clk

    // compensation runs must be z long, split in halves, and z*PER blocks apart
    task automatic check_stream(input logic use_lf, input logic [63:0] lf, input int z);
        int          run;
        int          seg;
        int          i;
        logic        seen;
        logic [63:0] nxt;
        logic [65:0] b;
        run = 0;
        seg = 0;
        seen = 1'b0;
        i = 2;
        while (i < out_q.size() && out_q[i][1:0] === SYNC_CTRL && out_q[i][9:2] === 8'h00)
            i++;
        nxt = out_q[i][65:2];
        for (; i < out_q.size(); i++)
        begin
            b = out_q[i];
            if (b[1:0] === SYNC_CTRL && b[9:2] === 8'h00)
            begin
                if (run == 0 && seen)
                    check(66'(seg), 66'(z * PER)); // period spacing
                run++;
                check(b[65:2], (run <= z / 2) ? RC_A : RC_B); // pattern halves
                seg = 0;
            end
            else
            begin
                if (run != 0)
                    check(66'(run), 66'(z)); // run length
                seen = seen | (run != 0);
                run = 0;
                seg++;
                check(b, use_lf ? {lf, SYNC_CTRL} : {nxt, SYNC_DATA}); // content
                nxt++;
            end
        end
        if (z > 0)
            check(66'(seen), 66'h1); // insertion seen
    endtask : check_stream

    task automatic complete_run();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        int lane;
        int last;
        int pulses;
        wait_clk(15);
        #1;
        check({map_vld_out, dmap_vld_out, parity_err_out}, 66'h0); // quiet in reset RESET
        @(posedge clock_in);
        rst_n_in <= 1'b1;
        #1;
        check(66'(map_sync_pos_out), 66'h1); // odd sync position
        $display("test reset done");
        foreach (rows[r])
        begin
            @(posedge clock_in);
            parity_rx_in <= rows[r].rx;
            parity_exp_in <= rows[r].exp;
            parity_chk_in <= rows[r].chk;
            @(posedge clock_in);
            #1;
            check(66'(parity_fwd_out), 66'(rows[r].rx)); // forwarded unchanged
            check(66'(parity_err_out), 66'(rows[r].err)); // compare monitor
        end
        $display("test parity done");
        wait_clk(30);
        out_q.delete();
        wait_clk(60);
        check_stream(1'b1, LF_PAYLOAD_55, 0); // 25G fail
        $display("test fail_25g done");
        @(posedge clock_in);
        client_los_in <= 1'b0;
        for (int t = 0; t < 2; t++)
        begin
            for (int f = 1; f >= 0; f--)
            begin
                @(posedge clock_in);
                client_type_in <= t ? CT_400G : CT_200G;
                lane_lock_in <= f ? (t ? 16'h7FFF : 16'h007F) : (t ? 16'hFFFF : 16'h00FF);
                src_en <= !f;
                wait_clk(40);
                out_q.delete();
                for (int j = 0; j < 700; j++)
                begin
                    @(posedge clock_in);
                    dmap_blk_in <= map_blk_out;
                    dmap_vld_in <= map_vld_out;
                    if (j > 80 && f && dmap_vld_out === 1'b1)
                        check(dmap_blk_out, {LF_PAYLOAD_4B, SYNC_CTRL}); // loopback
                end
                check(66'(dmap_lock_out), 66'h1); // loopback lock
                check_stream(f[0], LF_PAYLOAD_4B, t ? 32 : 16); // lanes and stream
                $display("test comp type %0d fail %0d done", t, f);
            end
        end
        @(posedge clock_in);
        src_en <= 1'b0;
        client_type_in <= CT_50G;
        lane_lock_in <= 16'h000F;
        dmap_blk_in <= 66'h3;
        lane = 0;
        for (int n = 0; n < 100; n++)
        begin
            @(posedge clock_in);
            dmap_vld_in <= 1'b1;
            dmap_blk_in <= {64'(n), SYNC_DATA};
            #1;
            if (n == 60)
                check(66'(dmap_lock_out), 66'h0); // no lock yet
            if (n > 80)
            begin
                check(dmap_vld_out ? dmap_blk_out : 66'h0, {64'(n - 1), SYNC_DATA}); // pass
                check(66'(dmap_lane_out), 66'((lane + 1) % 4)); // round robin
            end
            lane = dmap_lane_out;
        end
        @(posedge clock_in);
        dmap_blk_in <= {64'h0, 2'h3};
        @(posedge clock_in);
        dmap_blk_in <= {64'h0, SYNC_DATA};
        @(posedge clock_in);
        #1;
        check(66'(dmap_lock_out), 66'h0); // bad header drops lock
        $display("test demap_50g done");
        @(posedge clock_in);
        client_type_in <= CT_25G;
        client_los_in <= 1'b1;
        out_q.delete();
        fec_mode_in <= FM_BASER;
        last = -1;
        pulses = 0;
        for (int n = 0; n < 300; n++)
        begin
            @(posedge clock_in);
            dmap_blk_in <= {64'(n), SYNC_DATA};
            #1;
            if (n > 100)
                check(dmap_vld_out ? dmap_blk_out : 66'h0, {64'(n - 1), 2'h0}); // stripped
            if (n > 100 && dmap_parity_slot_out === 1'b1)
            begin
                if (last >= 0)
                    check(66'(n - last), 66'h20); // parity every 32 blocks
                last = n;
                pulses++;
            end
        end
        check(66'(pulses >= 6), 66'h1); // parity slots present
        check_stream(1'b1, LF_PAYLOAD_55, 0); // relapse replacement
        $display("test demap_baser done");
        @(posedge clock_in);
        dmap_vld_in <= 1'b0;
        complete_run();
    end
endmodule : test_epca_adapter
`default_nettype wire
